// file: verilog/trib_irq_pkg.sv
package trib_irq_pkg;
	// Number of tributary slices served by the aggregator
	localparam int SLICE_N = 3;
	// Register indices; the byte address is four times the index
	localparam logic [5:0] IDX_PAYLOAD_MF_EN = 6'h07;
	localparam logic [5:0] IDX_PAYLOAD_STATUS = 6'h08;
	localparam logic [5:0] IDX_CHANGE_FLAGS = 6'h09;
	localparam logic [5:0] IDX_OVH_TRACE_EN = 6'h0A;
	localparam logic [5:0] IDX_OVH_TRACE_STATUS = 6'h0B;
	localparam logic [5:0] IDX_MODE_CTRL = 6'h10;
	// Field positions inside the 8-bit registers
	localparam int PEND_LSB = 0;
	localparam int LIVE_LSB = 3;
	localparam int CHANGE_LSB = 3;
	localparam int PARITY_BIT = 7;
	localparam int KEEP_HIGH_LSB = 0;
	localparam int OVH_LSB = 0;
	localparam int TRACE_LSB = 3;
	localparam int PAY_EN_LSB = 0;
	localparam int MF_EN_LSB = 3;
	localparam int MODE_CONCAT_BIT = 0;
	localparam int MODE_PARITY_EN_BIT = 1;
	// Reset values
	localparam logic [2:0] KEEP_HIGH_RST = 3'h7;
	localparam logic [5:0] EN_RST = 6'h00;
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [7:0] READ_ZERO = 8'h00;
	// Bus answer sequencer, one-hot
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ANSWER = 2'b10
	} bus_state_t;
endpackage

// file: verilog/flag_if.sv
`timescale 1ns/1ps
interface flag_if #(parameter int N = 3);
	logic ce; // Clock enable from the top
	logic [N-1:0] frame_loss; // Framer loss-of-multiframe levels
	logic parity_err; // Incoming parity error event
	logic [N-1:0] change_clr; // Clear mask for change flags
	logic parity_clr; // Clear for the parity flag
	logic [N-1:0] change; // Sticky change flags
	logic parity_flag; // Sticky parity flag
	logic [N-1:0] live; // Registered live loss state
	// Top side drives events and clears
	modport ctrl (output ce, frame_loss, parity_err, change_clr, parity_clr, input change, parity_flag, live);
	// Detector side owns the flags
	modport det (input ce, frame_loss, parity_err, change_clr, parity_clr, output change, parity_flag, live);
endinterface // flag_if

// file: verilog/mf_change_detector.sv
`timescale 1ns/1ps
module mf_change_detector #(
	parameter int N = 3 // Slices watched
) (
	input wire logic clk_i, // Processing clock
	input wire logic rst_n_i, // Synchronised reset, active low
	flag_if.det f // Event and flag bundle
);
	logic [N-1:0] live_reg; // Framer state seen last cycle
	logic [N-1:0] change_reg; // Sticky change flags
	logic parity_reg; // Sticky parity flag

	// Track the framer state; this is also the live status bit
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			live_reg <= '0;
		end else if (f.ce) begin
			live_reg <= f.frame_loss;
		end
	end

	// Entry and exit both differ from the stored state
	// A new edge wins over a clear in the same cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			change_reg <= '0;
		end else if (f.ce) begin
			change_reg <= (change_reg & ~f.change_clr) | (f.frame_loss ^ live_reg);
		end
	end

	// Parity error latches until the flag register is read
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			parity_reg <= 1'b0;
		end else if (f.ce) begin
			parity_reg <= (parity_reg & ~f.parity_clr) | f.parity_err;
		end
	end

	assign f.live = live_reg;
	assign f.change = change_reg;
	assign f.parity_flag = parity_reg;
endmodule // mf_change_detector

// file: verilog/tributary_irq_aggregator.sv
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
module tributary_irq_aggregator #(
	parameter int SLICES = trib_irq_pkg::SLICE_N // Slices per device
) (
	input wire logic CLOCK_I, // Processing clock
	input wire logic RST_B_I, // Asynchronous reset, active low
	input wire logic CE_I, // Clock enable, freezes all state except the reset synchroniser when low
	input wire logic [7:0] ADDRESS_I, // Avalon byte address
	input wire logic READ_I, // Avalon read request
	input wire logic WRITE_I, // Avalon write request
	input wire logic [3:0] BYTEENABLE_I, // Avalon byte enables
	input wire logic [31:0] WRITEDATA_I, // Avalon write data
	output logic [31:0] READDATA_O, // Avalon read data
	output logic WAITREQUEST_O, // Avalon wait request
	input wire logic [2:0] PAYLOAD_PEND_I, // Payload processor pending levels
	input wire logic [2:0] OVERHEAD_PEND_I, // Overhead processor pending levels
	input wire logic [2:0] TRACE_PEND_I, // Trace buffer pending levels
	input wire logic [2:0] FRAME_LOSS_I, // Framer loss-of-multiframe levels
	input wire logic PARITY_ERR_I, // Incoming parity error pulse
	output logic [2:0] MF_ALIGN_LOSS_O, // Loss state used for alignment
	output logic IRQ_OUT_N_O // Shared interrupt, active low
);
	// The register layout is fixed at three slices per byte field
	if (SLICES != 3) begin : g_slice_check
		$error("tributary_irq_aggregator serves exactly three slices");
	end

	// The flag register packs its parity bit into lane zero
	if (trib_irq_pkg::PARITY_BIT > 7) begin : g_field_check
		$error("tributary_irq_aggregator parity bit outside lane zero");
	end

	// Reset release through two flops; assertion stays asynchronous
	// so the block is quiet even while the clock is stopped
	logic rst_meta_reg; // First synchroniser stage
	logic rst_n_reg; // Released reset used everywhere else

	// Bus sequencer
	// Two states only: every access costs exactly one wait cycle while the clock enable stays high
	trib_irq_pkg::bus_state_t bus_state_reg; // Current bus state
	trib_irq_pkg::bus_state_t bus_state_next; // Next bus state
	logic [7:0] read_data_reg; // Read value captured at request start
	logic [5:0] reg_idx; // Register index from the byte address
	logic addr_ok; // Address is word aligned
	logic req; // Any request present
	logic accept; // Edge at which the request completes

	// Software-visible control
	// Only defined fields are stored, so unused bits always read zero
	logic [2:0] payload_en_reg; // Payload processor top-level enables
	logic [2:0] mf_en_reg; // Multiframe loss interrupt enables
	logic [2:0] overhead_en_reg; // Overhead processor enables
	logic [2:0] trace_en_reg; // Trace buffer enables
	logic [2:0] keep_high_reg; // Keep-high reserved bits
	logic concat_mode_reg; // Incoming concatenation mode
	logic parity_en_reg; // Parity interrupt enable

	// Sampled pending levels
	// The sub-blocks own these levels and clear them on their own reads
	logic [2:0] payload_pend_reg; // Payload pending
	logic [2:0] overhead_pend_reg; // Overhead pending
	logic [2:0] trace_pend_reg; // Trace pending

	// Outputs held in flops
	// so the pins never glitch while flags and enables change
	logic irq_n_reg; // Interrupt pin value
	logic [2:0] align_loss_reg; // Alignment loss per slice
	logic [4:0] irq_src; // Enabled source per class

	// Bundle toward the change detector
	// Events go in, sticky flags and live bits come back
	flag_if #(.N(3)) flags ();

	// Decoded write hits on lane zero
	// Unaligned addresses and a low lane-zero enable change nothing
	function automatic logic wr_hit(input logic [5:0] idx, input logic [5:0] want, input logic ok,
		input logic lane);
		wr_hit = ok && lane && (idx == want);
	endfunction

	// Async assert, clocked release of the reset
	// Only the second stage is read elsewhere; the first may be unsettled
	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	// Address decode; unaligned addresses are treated as unmapped
	// Upper byte lanes carry nothing and read as zero
	assign reg_idx = ADDRESS_I[7:2];
	assign addr_ok = (ADDRESS_I[1:0] == 2'b00);
	assign req = READ_I | WRITE_I;
	assign accept = (bus_state_reg == trib_irq_pkg::BUS_ANSWER) && req && CE_I;

	// Every request waits one cycle while the clock enable is high; the first cycle captures read data
	// Trades one cycle of latency for a read value taken from a flop
	always_comb begin
		bus_state_next = bus_state_reg;
		case (bus_state_reg)
			trib_irq_pkg::BUS_IDLE: begin
				// Start answering any request
				// Read data are captured on this same edge
				if (req) begin
					bus_state_next = trib_irq_pkg::BUS_ANSWER;
				end
			end
			trib_irq_pkg::BUS_ANSWER: begin
				// Request completes here
				// The master drops its request after this edge
				bus_state_next = trib_irq_pkg::BUS_IDLE;
			end
			default: begin
				// Recover from an illegal code
				bus_state_next = trib_irq_pkg::BUS_IDLE;
			end
		endcase
	end

	// Bus state register
	// Frozen with the clock enable like every other state flop except the reset synchroniser
	always_ff @(posedge CLOCK_I or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			bus_state_reg <= trib_irq_pkg::BUS_IDLE;
		end else if (CE_I) begin
			bus_state_reg <= bus_state_next;
		end
	end

	// During a request low only in the answer cycle, so the master samples it once
	// Combinational, so a low clock enable stretches the wait
	assign WAITREQUEST_O = req && !((bus_state_reg == trib_irq_pkg::BUS_ANSWER) && CE_I);

	// Register read multiplexer; unmapped reads return zero
	// The captured copy also decides which flags the read clears,
	// so software never loses an event it did not see
	always_ff @(posedge CLOCK_I or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			read_data_reg <= trib_irq_pkg::READ_ZERO;
		end else if (CE_I && READ_I && (bus_state_reg == trib_irq_pkg::BUS_IDLE)) begin
			read_data_reg <= trib_irq_pkg::READ_ZERO;
			if (addr_ok) begin
				case (reg_idx)
					trib_irq_pkg::IDX_PAYLOAD_MF_EN: begin
						// Payload and multiframe enables
						read_data_reg[trib_irq_pkg::PAY_EN_LSB +: 3] <= payload_en_reg;
						read_data_reg[trib_irq_pkg::MF_EN_LSB +: 3] <= mf_en_reg;
					end
					trib_irq_pkg::IDX_PAYLOAD_STATUS: begin
						// Read-only payload pending and live loss
						// Live bits are raw framer state even when concatenated
						read_data_reg[trib_irq_pkg::PEND_LSB +: 3] <= payload_pend_reg;
						read_data_reg[trib_irq_pkg::LIVE_LSB +: 3] <= flags.live;
					end
					trib_irq_pkg::IDX_CHANGE_FLAGS: begin
						// Sticky flags plus keep-high bits
						// Bit 6 stays zero
						read_data_reg[trib_irq_pkg::PARITY_BIT] <= flags.parity_flag;
						read_data_reg[trib_irq_pkg::CHANGE_LSB +: 3] <= flags.change;
						read_data_reg[trib_irq_pkg::KEEP_HIGH_LSB +: 3] <= keep_high_reg;
					end
					trib_irq_pkg::IDX_OVH_TRACE_EN: begin
						// Overhead and trace enables
						read_data_reg[trib_irq_pkg::OVH_LSB +: 3] <= overhead_en_reg;
						read_data_reg[trib_irq_pkg::TRACE_LSB +: 3] <= trace_en_reg;
					end
					trib_irq_pkg::IDX_OVH_TRACE_STATUS: begin
						// Overhead and trace pending, reported even when masked
						read_data_reg[trib_irq_pkg::OVH_LSB +: 3] <= overhead_pend_reg;
						read_data_reg[trib_irq_pkg::TRACE_LSB +: 3] <= trace_pend_reg;
					end
					trib_irq_pkg::IDX_MODE_CTRL: begin
						// Mode and parity enable
						read_data_reg[trib_irq_pkg::MODE_CONCAT_BIT] <= concat_mode_reg;
						read_data_reg[trib_irq_pkg::MODE_PARITY_EN_BIT] <= parity_en_reg;
					end
					default: begin
						// Unmapped index reads zero
						read_data_reg <= trib_irq_pkg::READ_ZERO;
					end
				endcase
			end
		end
	end

	// Eight-bit registers sit in lane zero
	assign READDATA_O = {24'h000000, read_data_reg};

	// Payload and multiframe enable register
	// Enables mask only the pin; status bits report regardless
	always_ff @(posedge CLOCK_I or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			payload_en_reg <= trib_irq_pkg::EN_RST[2:0];
			mf_en_reg <= trib_irq_pkg::EN_RST[5:3];
		end else if (accept && WRITE_I && wr_hit(reg_idx, trib_irq_pkg::IDX_PAYLOAD_MF_EN, addr_ok,
			BYTEENABLE_I[0])) begin
			payload_en_reg <= WRITEDATA_I[trib_irq_pkg::PAY_EN_LSB +: 3];
			mf_en_reg <= WRITEDATA_I[trib_irq_pkg::MF_EN_LSB +: 3];
		end
	end

	// Keep-high bits are the only writable part of the flag register
	// They steer nothing inside; software is asked to keep them set
	always_ff @(posedge CLOCK_I or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			keep_high_reg <= trib_irq_pkg::KEEP_HIGH_RST;
		end else if (accept && WRITE_I && wr_hit(reg_idx, trib_irq_pkg::IDX_CHANGE_FLAGS, addr_ok,
			BYTEENABLE_I[0])) begin
			keep_high_reg <= WRITEDATA_I[trib_irq_pkg::KEEP_HIGH_LSB +: 3];
		end
	end

	// Overhead and trace enable register
	// Bits 7 and 6 are not stored and read back as zero
	always_ff @(posedge CLOCK_I or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			overhead_en_reg <= trib_irq_pkg::EN_RST[2:0];
			trace_en_reg <= trib_irq_pkg::EN_RST[5:3];
		end else if (accept && WRITE_I && wr_hit(reg_idx, trib_irq_pkg::IDX_OVH_TRACE_EN, addr_ok,
			BYTEENABLE_I[0])) begin
			overhead_en_reg <= WRITEDATA_I[trib_irq_pkg::OVH_LSB +: 3];
			trace_en_reg <= WRITEDATA_I[trib_irq_pkg::TRACE_LSB +: 3];
		end
	end

	// Mode register: concatenation and parity enable
	// Concatenation only steers the alignment outputs; live bits and
	// change detection always use the raw per-slice framer levels
	always_ff @(posedge CLOCK_I or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			concat_mode_reg <= trib_irq_pkg::MODE_RST[trib_irq_pkg::MODE_CONCAT_BIT];
			parity_en_reg <= trib_irq_pkg::MODE_RST[trib_irq_pkg::MODE_PARITY_EN_BIT];
		end else if (accept && WRITE_I && wr_hit(reg_idx, trib_irq_pkg::IDX_MODE_CTRL, addr_ok,
			BYTEENABLE_I[0])) begin
			concat_mode_reg <= WRITEDATA_I[trib_irq_pkg::MODE_CONCAT_BIT];
			parity_en_reg <= WRITEDATA_I[trib_irq_pkg::MODE_PARITY_EN_BIT];
		end
	end

	// Sample the sub-block pending levels; they only rise for
	// interrupts that the sub-block itself has enabled
	// One flop here adds one edge to the pending-to-pin path
	// Masked sources are sampled too, so status reads show them
	always_ff @(posedge CLOCK_I or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			payload_pend_reg <= 3'h0;
			overhead_pend_reg <= 3'h0;
			trace_pend_reg <= 3'h0;
		end else if (CE_I) begin
			payload_pend_reg <= PAYLOAD_PEND_I;
			overhead_pend_reg <= OVERHEAD_PEND_I;
			trace_pend_reg <= TRACE_PEND_I;
		end
	end

	// Drive the detector bundle
	// The clock enable travels with the bundle to freeze the flags too
	// Each high cycle of the parity input counts as one event
	assign flags.ce = CE_I;
	assign flags.frame_loss = FRAME_LOSS_I;
	assign flags.parity_err = PARITY_ERR_I;

	// Clear only the flags that the completing read actually returned,
	// so an edge arriving after the capture is not swallowed
	// Only a completing read of the flag register clears anything
	always_comb begin
		flags.change_clr = 3'h0;
		flags.parity_clr = 1'b0;
		if (accept && READ_I && addr_ok && (reg_idx == trib_irq_pkg::IDX_CHANGE_FLAGS)) begin
			flags.change_clr = read_data_reg[trib_irq_pkg::CHANGE_LSB +: 3];
			flags.parity_clr = read_data_reg[trib_irq_pkg::PARITY_BIT];
		end
	end

	// Change and parity flag keeper
	// Set and clear priority lives in one place, inside the detector
	mf_change_detector #(.N(3)) u_detector (
		.clk_i(CLOCK_I),
		.rst_n_i(rst_n_reg),
		.f(flags.det)
	);

	// Gather the enabled sources per class; a masked source stays
	// visible in its status register and only stays off the pin
	always_comb begin
		irq_src = 5'h00;
		irq_src[0] = |(payload_pend_reg & payload_en_reg);
		irq_src[1] = |(overhead_pend_reg & overhead_en_reg);
		irq_src[2] = |(trace_pend_reg & trace_en_reg);
		irq_src[3] = |(flags.change & mf_en_reg);
		irq_src[4] = flags.parity_flag & parity_en_reg;
	end

	// Shared interrupt: low while any enabled source is flagged
	always_ff @(posedge CLOCK_I or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			irq_n_reg <= 1'b1;
		end else if (CE_I) begin
			irq_n_reg <= ~(|irq_src);
		end
	end

	// Active low at the pin, released high out of reset
	assign IRQ_OUT_N_O = irq_n_reg;

	// In concat mode every slice follows the slice-one framer;
	// software should then keep slice two and three enables low
	// Alignment loss lags the framer input by two edges
	always_ff @(posedge CLOCK_I or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			align_loss_reg <= 3'h0;
		end else if (CE_I) begin
			align_loss_reg <= concat_mode_reg ? {3{flags.live[0]}} : flags.live;
		end
	end

	// Straight from the flop
	assign MF_ALIGN_LOSS_O = align_loss_reg;
endmodule // tributary_irq_aggregator

// file: verif/trib_irq_monitor.sv
`timescale 1ns/1ps
module trib_irq_monitor (
	input wire logic CLOCK_I, // Processing clock
	input wire logic RST_B_I, // Reset, active low
	input wire logic CE_I, // Clock enable
	input wire logic [7:0] ADDRESS_I, // Bus address
	input wire logic READ_I, // Read request
	input wire logic WRITE_I, // Write request
	input wire logic [3:0] BYTEENABLE_I, // Byte enables
	input wire logic [31:0] WRITEDATA_I, // Write data
	input wire logic [31:0] READDATA_O, // Read data
	input wire logic WAITREQUEST_O, // Wait request
	input wire logic [2:0] PAYLOAD_PEND_I, // Payload pending
	input wire logic [2:0] OVERHEAD_PEND_I, // Overhead pending
	input wire logic [2:0] TRACE_PEND_I, // Trace pending
	input wire logic [2:0] FRAME_LOSS_I, // Framer loss levels
	input wire logic PARITY_ERR_I, // Parity error pulse
	input wire logic [2:0] MF_ALIGN_LOSS_O, // Alignment loss
	input wire logic IRQ_OUT_N_O // Interrupt, active low
);
	logic acc; // Access completes at this edge
	logic wr_ok; // Write that lands in lane 0
	logic src; // Some pending input is enabled
	logic [5:0] en_pay_reg; // Copy of payload and loss enables
	logic [5:0] en_ovh_reg; // Copy of overhead and trace enables
	logic [1:0] mode_reg; // Copy of mode control
	logic [2:0] fl_prev_reg; // Framer levels at the last edge
	logic evt; // An enabled event is sampled now
	assign acc = (READ_I || WRITE_I) && !WAITREQUEST_O && CE_I;
	assign wr_ok = acc && WRITE_I && BYTEENABLE_I[0];
	assign src = |{PAYLOAD_PEND_I & en_pay_reg[2:0], OVERHEAD_PEND_I & en_ovh_reg[2:0], TRACE_PEND_I & en_ovh_reg[5:3]};
	assign evt = CE_I && (PARITY_ERR_I && mode_reg[1] || |((FRAME_LOSS_I ^ fl_prev_reg) & en_pay_reg[5:3]));
	// Previous framer levels, to see entry and exit edges
	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			fl_prev_reg <= 3'h0;
		end else begin
			fl_prev_reg <= FRAME_LOSS_I;
		end
	end
	// Follow the enable writes so the interrupt can be predicted from the pins alone
	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			en_pay_reg <= 6'h00;
			en_ovh_reg <= 6'h00;
			mode_reg <= 2'h0;
		end else if (wr_ok) begin
			case (ADDRESS_I)
				8'h1C: en_pay_reg <= WRITEDATA_I[5:0]; // Payload and loss enables
				8'h28: en_ovh_reg <= WRITEDATA_I[5:0]; // Overhead and trace enables
				8'h40: mode_reg <= WRITEDATA_I[1:0]; // Concat and parity enable
				default: ; // Other places hold no enable
			endcase
		end
	end
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RST_B_I);
	wait_first_a: assert property ($rose(READ_I || WRITE_I) |-> WAITREQUEST_O) else $error("request answered without wait");
	wait_bound_a: assert property ((READ_I || WRITE_I) && CE_I |-> ##[0:1] !WAITREQUEST_O)
		else $error("request not answered");
	ce_hold_a: assert property ((READ_I || WRITE_I) && !CE_I |-> WAITREQUEST_O) else $error("answer while frozen");
	rd_upper_a: assert property (acc && READ_I |-> READDATA_O[31:8] == 24'h000000) else $error("upper read bits set");
	status_gap_a: assert property (acc && READ_I && ADDRESS_I == 8'h20 |-> READDATA_O[7:6] == 2'h0)
		else $error("status unused set");
	flag_gap_a: assert property (acc && READ_I && ADDRESS_I == 8'h24 |-> !READDATA_O[6]) else $error("flag bit 6 set");
	irq_src_a: assert property (CE_I && src ##1 CE_I && src |=> !IRQ_OUT_N_O) else $error("enabled pending gave no irq");
	irq_event_a: assert property (evt ##1 CE_I |=> !IRQ_OUT_N_O) else $error("enabled event gave no irq");
	align_a: assert property ((CE_I && $stable(FRAME_LOSS_I) && !(wr_ok && ADDRESS_I == 8'h40))[*3]
		|-> MF_ALIGN_LOSS_O == (mode_reg[0] ? {3{FRAME_LOSS_I[0]}} : FRAME_LOSS_I)) else $error("alignment loss wrong");
	rst_quiet_a: assert property ($rose(RST_B_I) |-> IRQ_OUT_N_O && MF_ALIGN_LOSS_O == 3'h0) else $error("outputs active at reset");
endmodule // trib_irq_monitor

// file: verif/tributary_irq_aggregator_tb.sv
`timescale 1ns/1ps
module tributary_irq_aggregator_tb;
	typedef struct packed {logic [2:0] pay; logic [2:0] ovh; logic [2:0] trc;
		logic [7:0] en_p; logic [7:0] en_o; logic irq_n;} row_t;
	logic clk = 1'b0; // 25 MHz clock
	logic rst_b = 1'b0; // Reset, active low
	logic ce = 1'b1; // Clock enable
	logic [7:0] addr = 8'h00; // Bus address
	logic rd_i = 1'b0; // Read request
	logic wr_i = 1'b0; // Write request
	logic [3:0] be = 4'h0; // Byte enables
	logic [31:0] wdata = 32'h00000000; // Write data
	logic [31:0] rdata; // Read data
	logic waitreq; // Wait request
	logic [2:0] pay = 3'h0, ovh = 3'h0, trc = 3'h0; // Pending levels
	logic [2:0] fl = 3'h0; // Framer loss levels
	logic par = 1'b0; // Parity error pulse
	logic [2:0] align; // Alignment loss
	logic irq_n; // Interrupt, active low
	int n_fail = 0; // Mismatches
	int check_count = 0; // Comparisons
	// Ordinary cases: pending inputs, enables, expected interrupt
	row_t rows [9] = '{'{3'h1, 3'h0, 3'h0, 8'h00, 8'h00, 1'b1}, '{3'h1, 3'h0, 3'h0, 8'h01, 8'h00, 1'b0},
		'{3'h4, 3'h0, 3'h0, 8'h03, 8'h00, 1'b1}, '{3'h0, 3'h2, 3'h0, 8'h00, 8'h02, 1'b0},
		'{3'h0, 3'h4, 3'h0, 8'h00, 8'h38, 1'b1}, '{3'h0, 3'h0, 3'h4, 8'h00, 8'h20, 1'b0},
		'{3'h0, 3'h0, 3'h3, 8'h00, 8'h07, 1'b1}, '{3'h7, 3'h7, 3'h7, 8'h07, 8'h3F, 1'b0},
		'{3'h0, 3'h0, 3'h0, 8'h07, 8'h3F, 1'b1}};
	tributary_irq_aggregator dut (.CLOCK_I(clk), .RST_B_I(rst_b), .CE_I(ce), .ADDRESS_I(addr), .READ_I(rd_i),
		.WRITE_I(wr_i), .BYTEENABLE_I(be), .WRITEDATA_I(wdata), .READDATA_O(rdata), .WAITREQUEST_O(waitreq),
		.PAYLOAD_PEND_I(pay), .OVERHEAD_PEND_I(ovh), .TRACE_PEND_I(trc), .FRAME_LOSS_I(fl), .PARITY_ERR_I(par),
		.MF_ALIGN_LOSS_O(align), .IRQ_OUT_N_O(irq_n));
	// Free-running clock
	initial forever #20 clk = ~clk;
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Compare read data
	task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Compare output pins
	task automatic chk_pin(input logic [2:0] got, input logic [2:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Let edges pass, then look at settled outputs
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	// One bus cycle; held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] b,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		wdata <= {24'h000000, d};
		be <= b;
		wr_i <= w;
		rd_i <= !w;
		@(posedge clk);
		// Pre-edge values are what the slave sees at this edge
		while (waitreq !== 1'b0 && n < 40) begin
			@(posedge clk);
			n++;
		end
		if (n >= 40) n_fail++; // No answer counts as a mismatch
		q = rdata; // Read data taken at the accepting edge
		rd_i <= 1'b0;
		wr_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] b = 4'h1);
		logic [31:0] q;
		bus(1'b1, a, d, b, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, 4'h1, q);
		chk_rd(q, exp);
	endtask
	// One-cycle parity error
	task automatic pulse();
		@(posedge clk) par <= 1'b1;
		@(posedge clk) par <= 1'b0;
	endtask
	// Hang guard, far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		finish_test();
	end
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		tick(3);
		chk_pin({2'h0, irq_n}, 3'h1);
		rd(8'h1C, 32'h0);
		rd(8'h20, 32'h0);
		rd(8'h24, 32'h07);
		rd(8'h28, 32'h0);
		foreach (rows[i]) begin
			wr(8'h1C, rows[i].en_p);
			wr(8'h28, rows[i].en_o);
			@(posedge clk);
			pay <= rows[i].pay;
			ovh <= rows[i].ovh;
			trc <= rows[i].trc;
			tick(3);
			chk_pin({2'h0, irq_n}, {2'h0, rows[i].irq_n});
			rd(8'h20, {29'h0, rows[i].pay});
			rd(8'h2C, {26'h0, rows[i].trc, rows[i].ovh});
			rd(8'h28, {24'h0, rows[i].en_o});
			rd(8'h1C, {24'h0, rows[i].en_p});
		end
		// Masked loss changes are still flagged
		wr(8'h1C, 8'h00);
		@(posedge clk) fl <= 3'h5;
		tick(3);
		chk_pin({2'h0, irq_n}, 3'h1);
		rd(8'h20, 32'h28);
		rd(8'h24, 32'h2F);
		rd(8'h24, 32'h07);
		@(posedge clk) fl <= 3'h0;
		tick(3);
		rd(8'h24, 32'h2F);
		rd(8'h20, 32'h0);
		// Each slice enable gates entry and exit events
		for (int s = 0; s < 3; s++) begin
			wr(8'h1C, 8'(8'h08 << s));
			for (int v = 1; v >= 0; v--) begin
				@(posedge clk) fl <= v ? (3'h1 << s) : 3'h0;
				tick(3);
				chk_pin({2'h0, irq_n}, 3'h0);
				rd(8'h24, 32'h07 | (32'h08 << s));
				tick(2);
				chk_pin({2'h0, irq_n}, 3'h1);
			end
		end
		// Parity error, masked then enabled
		wr(8'h1C, 8'h00);
		pulse();
		tick(3);
		chk_pin({2'h0, irq_n}, 3'h1);
		rd(8'h24, 32'h87);
		rd(8'h24, 32'h07);
		wr(8'h40, 8'h02);
		rd(8'h40, 32'h2);
		pulse();
		tick(3);
		chk_pin({2'h0, irq_n}, 3'h0);
		rd(8'h24, 32'h87);
		tick(2);
		chk_pin({2'h0, irq_n}, 3'h1);
		// New error lands on the clearing edge and must survive it
		pulse();
		tick(2);
		fork
			rd(8'h24, 32'h87);
			begin
				@(posedge clk);
				@(posedge clk) par <= 1'b1;
				@(posedge clk) par <= 1'b0;
			end
		join
		rd(8'h24, 32'h87);
		rd(8'h24, 32'h07);
		// Concatenated mode takes alignment from slice one
		wr(8'h40, 8'h01);
		@(posedge clk) fl <= 3'h1;
		tick(3);
		chk_pin(align, 3'h7);
		rd(8'h20, 32'h08);
		@(posedge clk) fl <= 3'h6;
		tick(3);
		chk_pin(align, 3'h0);
		@(posedge clk) fl <= 3'h0;
		wr(8'h40, 8'h00);
		@(posedge clk) fl <= 3'h2;
		tick(3);
		chk_pin(align, 3'h2);
		@(posedge clk) fl <= 3'h0;
		tick(3);
		rd(8'h24, 32'h3F);
		// Read-only, unaligned, unmapped and lane-masked accesses
		wr(8'h20, 8'hFF);
		rd(8'h20, 32'h0);
		rd(8'h21, 32'h0);
		rd(8'h30, 32'h0);
		wr(8'h28, 8'h00, 4'h0);
		rd(8'h28, 32'h3F);
		wr(8'h24, 8'h00);
		rd(8'h24, 32'h0);
		wr(8'h24, 8'h07);
		// A frozen clock enable stretches the wait
		fork
			rd(8'h28, 32'h3F);
			begin
				@(posedge clk) ce <= 1'b0;
				repeat (3) @(posedge clk);
				ce <= 1'b1;
			end
		join
		// Reset in mid-run restores defaults
		@(posedge clk) rst_b <= 1'b0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		tick(3);
		rd(8'h28, 32'h0);
		rd(8'h24, 32'h07);
		chk_pin({2'h0, irq_n}, 3'h1);
		finish_test();
	end
endmodule // tributary_irq_aggregator_tb
bind tributary_irq_aggregator trib_irq_monitor u_mon (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .CE_I(CE_I),
	.ADDRESS_I(ADDRESS_I), .READ_I(READ_I), .WRITE_I(WRITE_I), .BYTEENABLE_I(BYTEENABLE_I), .WRITEDATA_I(WRITEDATA_I),
	.READDATA_O(READDATA_O), .WAITREQUEST_O(WAITREQUEST_O), .PAYLOAD_PEND_I(PAYLOAD_PEND_I),
	.OVERHEAD_PEND_I(OVERHEAD_PEND_I), .TRACE_PEND_I(TRACE_PEND_I), .FRAME_LOSS_I(FRAME_LOSS_I),
	.PARITY_ERR_I(PARITY_ERR_I), .MF_ALIGN_LOSS_O(MF_ALIGN_LOSS_O), .IRQ_OUT_N_O(IRQ_OUT_N_O));
